// [timing_event_pkg.sv]
package timing_event_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int FREQ_W = 19;
    localparam int FREQ_MSB = 18;
    localparam int FREQ_LSB = 16;
    localparam int NUM_REFS = 5;

    // Register addresses
    localparam logic [7:0] ADDR_INPUT_EVT = 8'h06;
    localparam logic [7:0] ADDR_FREQ_UPPER = 8'h07;
    localparam logic [7:0] ADDR_LOOP_EVT = 8'h08;

    // Reset values and implemented-bit masks
    localparam logic [7:0] RST_INPUT_EVT = 8'h3F;
    localparam logic [7:0] RST_LOOP_EVT = 8'h50;
    localparam logic [7:0] RST_FREQ_UPPER = 8'h00;
    localparam logic [7:0] MASK_INPUT_EVT = 8'h3E;
    localparam logic [7:0] MASK_LOOP_EVT = 8'hD8;

    // Field positions
    localparam int BIT_REF_TEN = 1;
    localparam int BIT_FRAME_SYNC = 7;
    localparam int BIT_AUX_LOCK = 6;
    localparam int BIT_AUX_NO_INPUTS = 4;
    localparam int BIT_LINE2_VIOL = 3;
endpackage : timing_event_pkg

// [timing_event_status_latches.sv]
// Overview of operation
// - Change flags for inputs ten to fourteen sit at bits 1..5, fourteen at 5.
// - A change flag sets on any validity toggle, either direction.
// - Flags hold until software writes one there; writing zero keeps them.
// - Frequency readback shows word bits 18..16 at bits 2..0; bits 7..3 zero.
// - Path select chooses main loop or auxiliary loop frequency.
// - Frame-sync monitor alarm latches bit 7 until software clears it.
// - Code violation on reference input two latches bit 3.
// - Loop event byte is readable, cleared by writing ones, resets to 0101 0000.
// - Loop event byte lives at register address 08 hex.
module timing_event_status_latches #(
    parameter int NUM_REFS = timing_event_pkg::NUM_REFS,
    parameter int FREQ_W = timing_event_pkg::FREQ_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [NUM_REFS-1:0] ref_input_valid,
    input wire logic frame_sync_alarm_event,
    input wire logic aux_loop_locked,
    input wire logic aux_loop_no_inputs,
    input wire logic line2_code_violation,
    input wire logic [FREQ_W-1:0] main_loop_freq,
    input wire logic [FREQ_W-1:0] aux_loop_freq,
    input wire logic path_select_aux
);

    logic [7:0] input_evt_r;
    logic [7:0] input_evt_nxt;
    logic [7:0] loop_evt_r;
    logic [7:0] loop_evt_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [NUM_REFS-1:0] ref_prev_r;
    logic aux_lock_prev_r;
    logic primed_r;
    logic [7:0] input_set;
    logic [7:0] loop_set;
    logic [7:0] input_clr;
    logic [7:0] loop_clr;
    logic [2:0] freq_upper;

    assign reg_rdata = rdata_r;

    // Edge history valid only after the first sampled cycle
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            primed_r <= 1'b0;
            ref_prev_r <= '0;
            aux_lock_prev_r <= 1'b0;
        end
        else
        begin
            primed_r <= 1'b1;
            ref_prev_r <= ref_input_valid;
            aux_lock_prev_r <= aux_loop_locked;
        end
    end

    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_input_set
            if (i >= timing_event_pkg::BIT_REF_TEN &&
                i < timing_event_pkg::BIT_REF_TEN + NUM_REFS)
            begin : g_ref
                localparam int R = i - timing_event_pkg::BIT_REF_TEN;
                assign input_set[i] = primed_r &&
                    (ref_input_valid[R] != ref_prev_r[R]);
            end
            else
            begin : g_none
                assign input_set[i] = 1'b0;
            end
        end
    endgenerate

    always_comb
    begin
        loop_set = 8'h00;
        loop_set[timing_event_pkg::BIT_FRAME_SYNC] = frame_sync_alarm_event;
        loop_set[timing_event_pkg::BIT_AUX_LOCK] =
            primed_r && (aux_loop_locked != aux_lock_prev_r);
        loop_set[timing_event_pkg::BIT_AUX_NO_INPUTS] = aux_loop_no_inputs;
        loop_set[timing_event_pkg::BIT_LINE2_VIOL] = line2_code_violation;
    end

    assign input_clr = (reg_wr && reg_addr == timing_event_pkg::ADDR_INPUT_EVT) ?
        reg_wdata : 8'h00;
    assign loop_clr = (reg_wr && reg_addr == timing_event_pkg::ADDR_LOOP_EVT) ?
        reg_wdata : 8'h00;

    // Set beats clear
    assign input_evt_nxt = ((input_evt_r & ~input_clr) | input_set) &
        timing_event_pkg::MASK_INPUT_EVT;
    assign loop_evt_nxt = ((loop_evt_r & ~loop_clr) | loop_set) &
        timing_event_pkg::MASK_LOOP_EVT;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            input_evt_r <= timing_event_pkg::RST_INPUT_EVT & timing_event_pkg::MASK_INPUT_EVT;
        end
        else
        begin
            input_evt_r <= input_evt_nxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            loop_evt_r <= timing_event_pkg::RST_LOOP_EVT;
        end
        else
        begin
            loop_evt_r <= loop_evt_nxt;
        end
    end

    assign freq_upper = path_select_aux ?
        aux_loop_freq[timing_event_pkg::FREQ_MSB:timing_event_pkg::FREQ_LSB] :
        main_loop_freq[timing_event_pkg::FREQ_MSB:timing_event_pkg::FREQ_LSB];

    always_comb
    begin
        rdata_nxt = 8'h00;
        unique case (reg_addr)
            timing_event_pkg::ADDR_INPUT_EVT: rdata_nxt = input_evt_r;
            timing_event_pkg::ADDR_FREQ_UPPER: rdata_nxt = {5'h00, freq_upper};
            timing_event_pkg::ADDR_LOOP_EVT: rdata_nxt = loop_evt_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rdata_r <= timing_event_pkg::RST_FREQ_UPPER;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_clear_ref_ten;
        reg_wr && reg_addr == timing_event_pkg::ADDR_INPUT_EVT &&
            reg_wdata[timing_event_pkg::BIT_REF_TEN];
    endsequence

    sequence s_quiet_ref_ten;
        !input_set[timing_event_pkg::BIT_REF_TEN];
    endsequence

    a_ref_fourteen_toggle: assert property (
        primed_r && ref_input_valid[NUM_REFS-1] != $past(ref_input_valid[NUM_REFS-1])
        |=> input_evt_r[5])
        else $error("input fourteen toggle did not set bit 5");

    a_ref_ten_edge: assert property (
        primed_r && $past(primed_r) && $changed(ref_input_valid[0]) |=> input_evt_r[1])
        else $error("input ten toggle did not set bit 1");

    a_clear_one_works: assert property (
        s_clear_ref_ten ##0 s_quiet_ref_ten |=> !input_evt_r[1])
        else $error("writing one did not clear input ten flag");

    a_write_zero_keeps: assert property (
        reg_wr && reg_addr == timing_event_pkg::ADDR_LOOP_EVT &&
            !reg_wdata[timing_event_pkg::BIT_LINE2_VIOL] && loop_evt_r[3]
        |=> loop_evt_r[3])
        else $error("writing zero cleared violation flag");

    a_freq_readback: assert property (
        reg_addr == timing_event_pkg::ADDR_FREQ_UPPER |=>
            reg_rdata == {5'h00, $past(path_select_aux) ? $past(aux_loop_freq[18:16]) :
                $past(main_loop_freq[18:16])})
        else $error("frequency readback wrong");

    a_sync_alarm_latch: assert property (
        frame_sync_alarm_event |=> loop_evt_r[7] ##1 (loop_evt_r[7] || $past(loop_clr[7])))
        else $error("frame sync alarm not held");

    a_aux_lock_change: assert property (
        primed_r && $past(primed_r) && $changed(aux_loop_locked) |=> loop_evt_r[6])
        else $error("aux lock change not latched");

    a_no_inputs_latch: assert property (
        aux_loop_no_inputs |=> loop_evt_r[4] && !loop_evt_r[5])
        else $error("aux no-inputs not latched");

    a_line2_violation: assert property (
        line2_code_violation |=> loop_evt_r[3])
        else $error("line two violation not latched");

    a_loop_byte_read: assert property (
        reg_addr == timing_event_pkg::ADDR_LOOP_EVT |=> reg_rdata == $past(loop_evt_r))
        else $error("loop event byte read wrong");

    a_set_beats_clear: assert property (
        loop_clr[3] && line2_code_violation |=> loop_evt_r[3])
        else $error("clear beat a simultaneous event");

    a_loop_reset_value: assert property (@(posedge clock) disable iff (1'b0)
        rst |=> loop_evt_r == timing_event_pkg::RST_LOOP_EVT)
        else $error("loop event byte reset value wrong");

endmodule : timing_event_status_latches

// [test_timing_event_status_latches.sv]
module test_timing_event_status_latches;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic sel; logic [18:0] m; logic [18:0] a; logic [7:0] exp;} row_s;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [4:0] ref_input_valid = 5'h00;
    logic frame_sync_alarm_event = 1'b0;
    logic aux_loop_locked = 1'b0;
    logic aux_loop_no_inputs = 1'b0;
    logic line2_code_violation = 1'b0;
    logic [18:0] main_loop_freq = 19'h00000;
    logic [18:0] aux_loop_freq = 19'h00000;
    logic path_select_aux = 1'b0;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    row_s rows [4] = '{'{1'b0, 19'h5FFFF, 19'h00000, 8'h05}, '{1'b1, 19'h5FFFF, 19'h30000, 8'h03},
        '{1'b0, 19'h70000, 19'h7FFFF, 8'h07}, '{1'b1, 19'h0FFFF, 19'h1FFFF, 8'h01}};
    logic [7:0] loop_bits [4] = '{8'h80, 8'h40, 8'h10, 8'h08};

    timing_event_status_latches i_timing_event_status_latches (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ref_input_valid(ref_input_valid),
        .frame_sync_alarm_event(frame_sync_alarm_event), .aux_loop_locked(aux_loop_locked),
        .aux_loop_no_inputs(aux_loop_no_inputs), .line2_code_violation(line2_code_violation),
        .main_loop_freq(main_loop_freq), .aux_loop_freq(aux_loop_freq),
        .path_select_aux(path_select_aux)
    );

    always #12.5 clock = ~clock;

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            error_cnt++;
            test_done();
        end
    end

    task test_done;
        if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    task step;
        @(posedge clock);
        #2;
    endtask : step

    task check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check8

    task rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        step();
        reg_addr = a;
        step();
        check8(name, exp, reg_rdata);
    endtask : rd

    task wr(input logic [7:0] a, input logic [7:0] d);
        step();
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step();
        reg_wr = 1'b0;
    endtask : wr

    task pulse(input int k);
        step();
        case (k)
            0: frame_sync_alarm_event = 1'b1;
            1: aux_loop_locked = ~aux_loop_locked;
            2: aux_loop_no_inputs = 1'b1;
            default: line2_code_violation = 1'b1;
        endcase
        step();
        frame_sync_alarm_event = 1'b0;
        aux_loop_no_inputs = 1'b0;
        line2_code_violation = 1'b0;
    endtask : pulse

    initial
    begin
        repeat (4) step();
        rst = 1'b0;
        step();
        rd(8'h06, 8'h3E, "input_change_event_flags");
        rd(8'h08, 8'h50, "loop_and_line_event_flags");
        rd(8'h07, 8'h00, "loop_frequency_upper_bits");
        foreach (rows[i])
        begin
            step();
            path_select_aux = rows[i].sel;
            main_loop_freq = rows[i].m;
            aux_loop_freq = rows[i].a;
            rd(8'h07, rows[i].exp, "loop_frequency_upper_bits");
        end
        wr(8'h07, 8'hFF);
        rd(8'h07, 8'h01, "loop_frequency_upper_bits");
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00, "unmapped");
        wr(8'h06, 8'hFF);
        wr(8'h08, 8'hFF);
        rd(8'h06, 8'h00, "input_change_event_flags");
        rd(8'h08, 8'h00, "loop_and_line_event_flags");
        for (int i = 0; i < 5; i++)
        begin
            ref_input_valid[i] = 1'b1;
            rd(8'h06, 8'h02 << i, "input_change_event_flags");
            wr(8'h06, 8'h02 << i);
            rd(8'h06, 8'h00, "input_change_event_flags");
        end
        ref_input_valid = 5'h00;
        wr(8'h06, 8'hC1);
        rd(8'h06, 8'h3E, "input_change_event_flags");
        wr(8'h06, 8'h3E);
        for (int k = 0; k < 4; k++)
        begin
            pulse(k);
            wr(8'h08, ~loop_bits[k]);
            rd(8'h08, loop_bits[k], "loop_and_line_event_flags");
            wr(8'h08, loop_bits[k]);
            rd(8'h08, 8'h00, "loop_and_line_event_flags");
        end
        pulse(1);
        rd(8'h08, 8'h40, "loop_and_line_event_flags");
        wr(8'h08, 8'h40);
        step();
        line2_code_violation = 1'b1;
        wr(8'h08, 8'h08);
        line2_code_violation = 1'b0;
        rd(8'h08, 8'h08, "loop_and_line_event_flags");
        ref_input_valid[0] = 1'b1;
        rd(8'h06, 8'h02, "input_change_event_flags");
        rst = 1'b1;
        rd(8'h08, 8'h00, "reg_rdata");
        rst = 1'b0;
        rd(8'h08, 8'h50, "loop_and_line_event_flags");
        rd(8'h06, 8'h3E, "input_change_event_flags");
        test_done();
    end
endmodule : test_timing_event_status_latches
